// *** hdl/lan_port_pkg.sv ***
// Constants and types for the LAN card local-side port
package lan_port_pkg;

    localparam int  CLK_MHZ          = 40;
    localparam int  CLK_PERIOD_NS    = 1000 / CLK_MHZ;
    localparam int  NIC_ACK_WAIT_MAX = 64;
    localparam int  COP_ADDR_W       = 4;
    localparam logic [1:0] STRAP_NIC = 2'h1;

    typedef enum logic [1:0]
    {
        NIC_IDLE   = 2'b00,
        NIC_STROBE = 2'b01,
        NIC_DONE   = 2'b11
    } nic_state_t;

endpackage

// *** hdl/lan_card_local_side_port.sv ***
// Local-side port: network-controller control or coprocessor slave, chosen by strap
//
// Contract
// RULE1: Strap selects mode; open strap means network mode
// RULE2: Strap low switches shared pins to coprocessor
// RULE3: Controller DMA request answered by bus grant
// RULE4: Reset output forces network controller reset
// RULE5: Register reads use chip select and read strobe
// RULE6: Register writes use chip select and write strobe
// RULE7: Wait states until controller acknowledges access
// RULE8: Everything runs from one clock input
// RULE9: Coprocessor DMA request signals host transfer wish
// RULE10: Coprocessor asserts grant when its channel grants
// RULE11: Coprocessor addresses registers on shared pins
// RULE12: Coprocessor uses chip select with read/write strobe
// RULE13: Ready output waits while access needs time
// RULE14: Interrupt output flags host request to coprocessor
// RULE15: Terminal count negates coprocessor DMA request
// RULE16: Buffer memory read gate drives reads
// RULE17: Buffer memory write gate for host writes
// RULE18: Boot ROM select acts as ROM chip select
// RULE19: Direction output steers external data buffers
// RULE20: Enable output switches external data buffers
// RULE21: Memory decode output carries unlatched decode; code registers it, one clock late
// RULE22: Controller interrupt input means host attention
// RULE23: Memory controls released during controller DMA
// RULE24: Host control bit raises coprocessor DMA request
// RULE25: Buffers disabled while controller holds grant
`timescale 1ns/1ns
module lan_card_local_side_port
    import lan_port_pkg::*;
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  mode_strap_i,
    input  wire logic                  nic_dma_request_i,
    input  wire logic                  nic_ack_i,
    input  wire logic                  nic_irq_i,
    input  wire logic                  host_nic_reset_i,
    input  wire logic                  host_reg_rd_i,
    input  wire logic                  host_reg_wr_i,
    input  wire logic                  host_mem_rd_i,
    input  wire logic                  host_mem_wr_i,
    input  wire logic                  host_rom_rd_i,
    input  wire logic                  host_mem_decode_i,
    input  wire logic                  host_dma_req_set_i,
    input  wire logic                  host_cop_attn_i,
    input  wire logic                  cop_dma_grant_i,
    input  wire logic                  cop_transfer_done_n_i,
    input  wire logic [COP_ADDR_W-1:0] cop_reg_addr_i,
    input  wire logic                  cop_cs_n_i,
    input  wire logic                  cop_read_strobe_n_i,
    input  wire logic                  cop_write_strobe_n_i,
    input  wire logic                  cop_reg_busy_i,
    output logic                       nic_mode_o,
    output logic                       nic_bus_grant_o,
    output logic                       nic_reset_n_o,
    output logic                       nic_cs_n_o,
    output logic                       nic_reg_read_strobe_n_o,
    output logic                       nic_reg_write_strobe_n_o,
    output logic                       nic_access_done_o,
    output logic                       nic_irq_o,
    output logic                       cop_dma_request_o,
    output logic                       cop_wait_request_n_o,
    output logic                       cop_interrupt_out_o,
    output logic                       cop_reg_rd_o,
    output logic                       cop_reg_wr_o,
    output logic [COP_ADDR_W-1:0]      cop_reg_addr_o,
    output logic                       buffer_mem_read_gate_n_o,
    output logic                       buffer_mem_write_gate_n_o,
    output logic                       buffer_mem_ctl_oe_o,
    output logic                       boot_rom_select_n_o,
    output logic                       buffer_direction_n_o,
    output logic                       buffer_gate_enable_n_o,
    output logic                       memory_decode_out_n_o
);

    typedef struct packed {
        logic                  strap_seen;
        logic                  nic_mode;
        nic_state_t            nic_st;
        logic                  grant;
        logic                  rst_n;
        logic                  cs_n;
        logic                  rd_n;
        logic                  wr_n;
        logic                  done;
        logic                  irq;
        logic                  dreq;
        logic                  wait_n;
        logic                  attn;
        logic                  crd;
        logic                  cwr;
        logic [COP_ADDR_W-1:0] caddr;
        logic                  buffer_mem_read_gate_n;
        logic                  buffer_mem_write_gate_n;
        logic                  ram_oe;
        logic                  rom_n;
        logic                  dir_n;
        logic                  den_n;
        logic                  memory_decode_out_n;
    } state_t;

    state_t s_reg;
    state_t s_next;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic; strap is caught once after reset release, since the
    // pin sharing must not change under a running access
    always_comb
    begin
        s_next = s_reg;
        if (!s_reg.strap_seen)
        begin
            s_next.strap_seen = 1'b1;
            s_next.nic_mode   = mode_strap_i;   // RULE1 RULE2
        end
        if (s_reg.nic_mode)
        begin
            s_next.grant  = nic_dma_request_i;  // RULE3
            s_next.rst_n  = !host_nic_reset_i;  // RULE4
            s_next.irq    = nic_irq_i;
            s_next.done   = 1'b0;
            unique case (s_reg.nic_st)
                NIC_IDLE:
                begin
                    if ((host_reg_rd_i || host_reg_wr_i) && !s_reg.grant)
                    begin
                        s_next.cs_n   = 1'b0;   // RULE5 RULE6
                        s_next.rd_n   = !host_reg_rd_i; // RULE5
                        s_next.wr_n   = host_reg_rd_i;  // RULE6
                        s_next.nic_st = NIC_STROBE;
                    end
                end
                NIC_STROBE:
                begin
                    if (nic_ack_i)              // RULE7
                    begin
                        s_next.cs_n   = 1'b1;
                        s_next.rd_n   = 1'b1;
                        s_next.wr_n   = 1'b1;
                        s_next.done   = 1'b1;
                        s_next.nic_st = NIC_DONE;
                    end
                end
                NIC_DONE:
                begin
                    s_next.nic_st = NIC_IDLE;
                end
                default:
                begin
                    s_next.nic_st = NIC_IDLE;
                end
            endcase
            // Controller DMA owns the local bus: memory controls go high-Z
            s_next.ram_oe  = !nic_dma_request_i;             // RULE23
            s_next.buffer_mem_read_gate_n = !(host_mem_rd_i && !nic_dma_request_i); // RULE16
            s_next.buffer_mem_write_gate_n = !(host_mem_wr_i && !nic_dma_request_i); // RULE17
            s_next.den_n   = nic_dma_request_i;              // RULE20 RULE25
            s_next.dreq    = 1'b0;
            s_next.wait_n  = 1'b1;
            s_next.attn    = 1'b0;
            s_next.crd     = 1'b0;
            s_next.cwr     = 1'b0;
        end
        else
        begin
            // Terminal count dominates so a finished packet cannot re-request
            if (!cop_transfer_done_n_i)
                s_next.dreq = 1'b0;             // RULE15
            else if (host_dma_req_set_i)
                s_next.dreq = 1'b1;             // RULE9 RULE24
            s_next.attn  = host_cop_attn_i;     // RULE14
            s_next.caddr = cop_reg_addr_i;      // RULE11
            s_next.crd   = !cop_cs_n_i && !cop_read_strobe_n_i;  // RULE12
            s_next.cwr   = !cop_cs_n_i && !cop_write_strobe_n_i; // RULE12
            s_next.wait_n = !(!cop_cs_n_i && cop_reg_busy_i);    // RULE13
            s_next.grant  = 1'b0;
            s_next.rst_n  = 1'b1;
            s_next.cs_n   = 1'b1;
            s_next.rd_n   = 1'b1;
            s_next.wr_n   = 1'b1;
            s_next.done   = 1'b0;
            s_next.irq    = 1'b0;
            s_next.nic_st = NIC_IDLE;
            s_next.ram_oe = 1'b0;
            s_next.buffer_mem_read_gate_n = 1'b1;
            s_next.buffer_mem_write_gate_n = 1'b1;
            s_next.den_n  = cop_dma_grant_i;    // RULE10 RULE20
        end
        s_next.rom_n  = !host_rom_rd_i;         // RULE18
        s_next.dir_n  = !(host_mem_rd_i || host_rom_rd_i || host_reg_rd_i); // RULE19
        s_next.memory_decode_out_n = !host_mem_decode_i;     // RULE21
    end

    ////////////////////////////////////////////////////////////////////////////
    // Single clock domain register
    always_ff @(posedge ref_clk_i)              // RULE8
    begin
        if (rst_i)
        begin
            s_reg         <= '0;
            s_reg.nic_mode <= 1'b1;
            s_reg.nic_st  <= NIC_IDLE;
            s_reg.rst_n   <= 1'b0;
            s_reg.cs_n    <= 1'b1;
            s_reg.rd_n    <= 1'b1;
            s_reg.wr_n    <= 1'b1;
            s_reg.wait_n  <= 1'b1;
            s_reg.buffer_mem_read_gate_n <= 1'b1;
            s_reg.buffer_mem_write_gate_n <= 1'b1;
            s_reg.rom_n   <= 1'b1;
            s_reg.dir_n   <= 1'b1;
            s_reg.den_n   <= 1'b1;
            s_reg.memory_decode_out_n  <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign nic_mode_o                = s_reg.nic_mode;
    assign nic_bus_grant_o           = s_reg.grant;
    assign nic_reset_n_o             = s_reg.rst_n;
    assign nic_cs_n_o                = s_reg.cs_n;
    assign nic_reg_read_strobe_n_o   = s_reg.rd_n;
    assign nic_reg_write_strobe_n_o  = s_reg.wr_n;
    assign nic_access_done_o         = s_reg.done;
    assign nic_irq_o                 = s_reg.irq;   // RULE22
    assign cop_dma_request_o         = s_reg.dreq;
    assign cop_wait_request_n_o      = s_reg.wait_n;
    assign cop_interrupt_out_o       = s_reg.attn;
    assign cop_reg_rd_o              = s_reg.crd;
    assign cop_reg_wr_o              = s_reg.cwr;
    assign cop_reg_addr_o            = s_reg.caddr;
    assign buffer_mem_read_gate_n_o  = s_reg.buffer_mem_read_gate_n;
    assign buffer_mem_write_gate_n_o = s_reg.buffer_mem_write_gate_n;
    assign buffer_mem_ctl_oe_o       = s_reg.ram_oe;
    assign boot_rom_select_n_o       = s_reg.rom_n;
    assign buffer_direction_n_o      = s_reg.dir_n;
    assign buffer_gate_enable_n_o    = s_reg.den_n;
    assign memory_decode_out_n_o     = s_reg.memory_decode_out_n;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence req_seen;
        s_reg.nic_mode && nic_dma_request_i;
    endsequence

    a_grant_follows: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE3
        req_seen |=> nic_bus_grant_o)
        else $error("grant did not follow request");

    a_buffers_isolated: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE25
        (s_reg.nic_mode && nic_bus_grant_o) |-> buffer_gate_enable_n_o)
        else $error("buffers enabled during grant");

    a_reset_follows: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE4
        (s_reg.nic_mode && host_nic_reset_i) |=> !nic_reset_n_o)
        else $error("controller reset not driven");

    a_read_pairs_cs: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE5
        !nic_reg_read_strobe_n_o |-> !nic_cs_n_o)
        else $error("read strobe without chip select");

    a_write_pairs_cs: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE6
        !nic_reg_write_strobe_n_o |-> !nic_cs_n_o)
        else $error("write strobe without chip select");

    a_wait_for_ack: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE7
        (!nic_cs_n_o && !nic_ack_i && s_reg.nic_mode) |=> !nic_cs_n_o)
        else $error("access ended without acknowledge");

    a_tc_clears_req: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE15
        (!s_reg.nic_mode && !cop_transfer_done_n_i) |=> !cop_dma_request_o)
        else $error("terminal count did not clear request");

    a_req_set_bit: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE24
        (!s_reg.nic_mode && host_dma_req_set_i && cop_transfer_done_n_i)
        |=> cop_dma_request_o)
        else $error("request bit did not raise request");

    a_mem_hiz_dma: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE23
        (s_reg.nic_mode && nic_dma_request_i) |=> !buffer_mem_ctl_oe_o)
        else $error("memory controls driven during dma");

    a_cop_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE13
        (!s_reg.nic_mode && !cop_cs_n_i && cop_reg_busy_i) |=> !cop_wait_request_n_o)
        else $error("ready not held in wait");

    // An acknowledged access must close at once and flag completion
    sequence access_acked;
        s_reg.nic_mode && !nic_cs_n_o && nic_ack_i;
    endsequence

    a_access_ends: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE7
        access_acked |=> (nic_cs_n_o && nic_access_done_o))
        else $error("access did not end on acknowledge");

    a_ram_read_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE16
        (s_reg.nic_mode && host_mem_rd_i && !nic_dma_request_i) |=> !buffer_mem_read_gate_n_o)
        else $error("buffer read gate not driven");

    a_ram_write_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE17
        (s_reg.nic_mode && host_mem_wr_i && !nic_dma_request_i) |=> !buffer_mem_write_gate_n_o)
        else $error("buffer write gate not driven");

    a_rom_select: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE18
        host_rom_rd_i |=> !boot_rom_select_n_o)
        else $error("rom select not driven");

    a_cop_attn: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE14
        (!s_reg.nic_mode && host_cop_attn_i) |=> cop_interrupt_out_o)
        else $error("coprocessor interrupt not raised");

endmodule

// *** testbench/nic_model.sv ***
// Behavioural network controller facing the local-side port
`timescale 1ns/1ns
module nic_model
(
    input  wire logic       ref_clk_i,
    input  wire logic       cs_n_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic       dma_want_i,
    input  wire logic       irq_want_i,
    input  wire logic [3:0] ack_delay_i,
    output logic            dma_request_o,
    output logic            ack_o,
    output logic            irq_o
);
    int cnt = 0;

    initial
    begin
        {dma_request_o, ack_o, irq_o} = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Acknowledge only after the strobe has been held for the chosen delay,
    // and drop it with the strobe so a stale acknowledge never leaks on
    always @(posedge ref_clk_i)
    begin
        if (!cs_n_i && !(rd_n_i && wr_n_i))
        begin
            ack_o <= (cnt >= ack_delay_i);
            cnt <= cnt + 1;
        end
        else
        begin
            ack_o <= 1'h0;
            cnt <= 0;
        end
        dma_request_o <= dma_want_i;
        irq_o <= irq_want_i;
    end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the LAN card local-side port
`timescale 1ns/1ns
module tb;
    import lan_port_pkg::*;
    localparam int LIMIT = 20000;
    logic ref_clk_i = 1'h0, rst_i = 1'h1, mode_strap_i = 1'h1;
    logic nic_dma_request_i, nic_ack_i, nic_irq_i, host_nic_reset_i, host_reg_rd_i;
    logic host_reg_wr_i, host_mem_rd_i, host_mem_wr_i, host_rom_rd_i, host_mem_decode_i;
    logic host_dma_req_set_i, host_cop_attn_i, cop_dma_grant_i, cop_transfer_done_n_i;
    logic cop_cs_n_i, cop_read_strobe_n_i, cop_write_strobe_n_i, cop_reg_busy_i;
    logic [COP_ADDR_W-1:0] cop_reg_addr_i, cop_reg_addr_o, p_addr;
    logic nic_mode_o, nic_bus_grant_o, nic_reset_n_o, nic_cs_n_o, nic_reg_read_strobe_n_o;
    logic nic_reg_write_strobe_n_o, nic_access_done_o, nic_irq_o, cop_dma_request_o;
    logic cop_wait_request_n_o, cop_interrupt_out_o, cop_reg_rd_o, cop_reg_wr_o;
    logic buffer_mem_read_gate_n_o, buffer_mem_write_gate_n_o, buffer_mem_ctl_oe_o;
    logic boot_rom_select_n_o, buffer_direction_n_o, buffer_gate_enable_n_o;
    logic memory_decode_out_n_o, dma_want, irq_want, rnd_on = 1'h0, m_dma = 1'h0;
    logic p_dma, p_irq, p_nrst, p_mrd, p_mwr, p_rom, p_dec, p_attn, p_cs, p_rd, p_wr, p_busy;
    logic p_rrd, p_gnt;
    logic [3:0] ack_delay = 4'h0;
    int mode_chk = 0, mismatches = 0, tests_run = 0, cycles = 0, seed = 32'h88cb9aac;

    always #5 ref_clk_i = ~ref_clk_i;

    lan_card_local_side_port DUT
    (
        .ref_clk_i, .rst_i, .mode_strap_i, .nic_dma_request_i, .nic_ack_i, .nic_irq_i,
        .host_nic_reset_i, .host_reg_rd_i, .host_reg_wr_i, .host_mem_rd_i, .host_mem_wr_i,
        .host_rom_rd_i, .host_mem_decode_i, .host_dma_req_set_i, .host_cop_attn_i,
        .cop_dma_grant_i, .cop_transfer_done_n_i, .cop_reg_addr_i, .cop_cs_n_i,
        .cop_read_strobe_n_i, .cop_write_strobe_n_i, .cop_reg_busy_i, .nic_mode_o,
        .nic_bus_grant_o, .nic_reset_n_o, .nic_cs_n_o, .nic_reg_read_strobe_n_o,
        .nic_reg_write_strobe_n_o, .nic_access_done_o, .nic_irq_o, .cop_dma_request_o,
        .cop_wait_request_n_o, .cop_interrupt_out_o, .cop_reg_rd_o, .cop_reg_wr_o,
        .cop_reg_addr_o, .buffer_mem_read_gate_n_o, .buffer_mem_write_gate_n_o,
        .buffer_mem_ctl_oe_o, .boot_rom_select_n_o, .buffer_direction_n_o,
        .buffer_gate_enable_n_o, .memory_decode_out_n_o
    );

    nic_model partner
    (
        .ref_clk_i, .cs_n_i(nic_cs_n_o), .rd_n_i(nic_reg_read_strobe_n_o),
        .wr_n_i(nic_reg_write_strobe_n_o), .dma_want_i(dma_want), .irq_want_i(irq_want),
        .ack_delay_i(ack_delay), .dma_request_o(nic_dma_request_i), .ack_o(nic_ack_i),
        .irq_o(nic_irq_i)
    );

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Sample what the design saw on each edge; the sticky request model lets clear win
    always @(posedge ref_clk_i)
    begin
        {p_dma, p_irq, p_nrst, p_mrd, p_mwr, p_rom, p_dec} = {nic_dma_request_i, nic_irq_i,
            host_nic_reset_i, host_mem_rd_i, host_mem_wr_i, host_rom_rd_i, host_mem_decode_i};
        {p_attn, p_cs, p_rd, p_wr, p_busy, p_addr} = {host_cop_attn_i, cop_cs_n_i,
            cop_read_strobe_n_i, cop_write_strobe_n_i, cop_reg_busy_i, cop_reg_addr_i};
        {p_rrd, p_gnt} = {host_reg_rd_i, cop_dma_grant_i};
        if (rst_i || !cop_transfer_done_n_i)
            m_dma = 1'h0;
        else if (host_dma_req_set_i)
            m_dma = 1'h1;
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            end_of_test();
        end
    end

    // Compare the active mode's registered outputs, except the controller chip select, strobes and done flag, then drive fresh random stimulus
    always @(negedge ref_clk_i)
    begin
        if (mode_chk == 1)
        begin
            check("mode", nic_mode_o, 1'h1);
            check("grant", nic_bus_grant_o, p_dma);
            check("irq", nic_irq_o, p_irq);
            check("nic_rst_n", nic_reset_n_o, !p_nrst);
            check("ctl_oe", buffer_mem_ctl_oe_o, !p_dma);
            check("buf_en_n", buffer_gate_enable_n_o, p_dma);
            check("rom_n", boot_rom_select_n_o, !p_rom);
            check("decode_n", memory_decode_out_n_o, !p_dec);
            check("dir_n", buffer_direction_n_o, !(p_mrd || p_rom || p_rrd));
            if (!p_dma)
                check("ram_rd_n", buffer_mem_read_gate_n_o, !p_mrd);
            if (!p_dma)
                check("ram_wr_n", buffer_mem_write_gate_n_o, !p_mwr);
        end
        if (mode_chk == 2)
        begin
            check("mode", nic_mode_o, 1'h0);
            check("cop_grant", nic_bus_grant_o, 1'h0);
            check("cop_ctl_oe", buffer_mem_ctl_oe_o, 1'h0);
            check("cop_buf_en_n", buffer_gate_enable_n_o, p_gnt);
            check("cop_rom_n", boot_rom_select_n_o, !p_rom);
            check("cop_decode_n", memory_decode_out_n_o, !p_dec);
            check("cop_dir_n", buffer_direction_n_o, !(p_mrd || p_rom || p_rrd));
            check("cop_req", cop_dma_request_o, m_dma);
            check("cop_int", cop_interrupt_out_o, p_attn);
            check("wait_n", cop_wait_request_n_o, !(!p_cs && p_busy));
            check("cop_rd", cop_reg_rd_o, !p_cs && !p_rd);
            check("cop_wr", cop_reg_wr_o, !p_cs && !p_wr);
            if (!p_cs)
                check("cop_addr", cop_reg_addr_o, p_addr);
        end
        if (rnd_on)
        begin
            {host_mem_rd_i, host_mem_wr_i} = 2'h3 & (2'h1 << ($random(seed) & 3));
            {host_rom_rd_i, host_mem_decode_i, dma_want, irq_want, host_dma_req_set_i,
             host_cop_attn_i, cop_dma_grant_i, cop_reg_busy_i} = 8'($random(seed));
            host_nic_reset_i = ($random(seed) & 3) == 0;
            cop_transfer_done_n_i = ($random(seed) & 7) != 0;
            cop_cs_n_i = 1'($random(seed));
            cop_reg_addr_i = 4'($random(seed));
            {cop_read_strobe_n_i, cop_write_strobe_n_i} = ~(2'h3 & (2'h1 << ($random(seed) & 3)));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Idle every input, hold reset five cycles, then check the quiet state
    task automatic do_reset(input logic strap);
        mode_chk = 0;
        {host_nic_reset_i, host_reg_rd_i, host_reg_wr_i, host_mem_rd_i, host_mem_wr_i,
         host_rom_rd_i, host_mem_decode_i, host_dma_req_set_i, host_cop_attn_i,
         cop_dma_grant_i, cop_reg_busy_i, dma_want, irq_want} = '0;
        {cop_transfer_done_n_i, cop_cs_n_i, cop_read_strobe_n_i, cop_write_strobe_n_i} = 4'hf;
        cop_reg_addr_i = 4'h0;
        mode_strap_i = strap;
        rst_i = 1'h1;
        repeat (5) @(negedge ref_clk_i);
        check("rst_nic_rst_n", nic_reset_n_o, 1'h0);
        check("rst_buf_en_n", buffer_gate_enable_n_o, 1'h1);
        check("rst_cs_n", nic_cs_n_o, 1'h1);
        check("rst_cop_req", cop_dma_request_o, 1'h0);
        rst_i = 1'h0;
        repeat (2) @(negedge ref_clk_i);
        mode_chk = strap ? 1 : 2;
    endtask

    // One controller register access; strobes must stand until acknowledge
    task automatic nic_access(input logic rd, input int w);
        int n;
        n = 0;
        ack_delay = 4'(w);
        host_reg_rd_i = rd;
        host_reg_wr_i = !rd;
        while (nic_access_done_o !== 1'h1 && n < 40)
        begin
            @(negedge ref_clk_i);
            if (nic_access_done_o !== 1'h1 && nic_cs_n_o === 1'h0)
            begin
                n++;
                check("rd_strobe_n", nic_reg_read_strobe_n_o, !rd);
                check("wr_strobe_n", nic_reg_write_strobe_n_o, rd);
            end
        end
        check("wait_states", 8'(n), 8'(2 + w));
        check("cs_released", nic_cs_n_o, 1'h1);
        host_reg_rd_i = 1'h0;
        host_reg_wr_i = 1'h0;
        @(negedge ref_clk_i);
        check("done_pulse", nic_access_done_o, 1'h0);
    endtask

    initial
    begin
        do_reset(1'h1);
        rnd_on = 1'h1;
        repeat (2000) @(negedge ref_clk_i);
        rnd_on = 1'h0;
        @(negedge ref_clk_i);
        host_nic_reset_i = 1'h0;
        dma_want = 1'h1;
        repeat (3) @(negedge ref_clk_i);
        // A request while the controller owns the bus must wait for the grant to drop
        host_reg_rd_i = 1'h1;
        repeat (4) @(negedge ref_clk_i) check("cs_n_granted", nic_cs_n_o, 1'h1);
        dma_want = 1'h0;
        nic_access(1'h1, 1);
        for (int i = 0; i < 40; i++)
            nic_access(1'($random(seed)), $random(seed) & 7);
        rnd_on = 1'h0;
        @(negedge ref_clk_i);
        do_reset(1'h0);
        rnd_on = 1'h1;
        repeat (3000) @(negedge ref_clk_i);
        end_of_test();
    end
endmodule
